//--- bench/pcc_commit_sva.sv
// Purpose: Port checker for the commit control block
// Assumes: One clock domain, answer one edge after a write
// Notes: Applied values show two edges after their cause
`timescale 1ns/1ps
`default_nettype none
module pcc_commit_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Host side
   input wire logic hostWrEn,
   input wire logic [3:0] hostWrIdx,
   input wire logic [31:0] hostWrData,
   input wire logic motorStopped,
   input wire logic cfgCmd,
   input wire logic powerUp,
   // Block outputs
   input wire logic wrAccepted_ff,
   input wire logic wrRejected_ff,
   input wire logic [12:0] pending_ff,
   input wire logic [31:0] trqMax_ff,
   input wire logic [31:0] spdGain_ff,
   input wire logic threeWire_ff,
   input wire logic startInhibit_ff,
   input wire logic [31:0] classB_ff,
   input wire logic [31:0] classD_ff
);
   import pcc_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Write of one index
   sequence s_wr(logic [3:0] i);
      hostWrEn && hostWrIdx == i;
   endsequence
   a_write_answer: assert property (hostWrEn |=> wrAccepted_ff != wrRejected_ff)
      else $error("write without single answer");
   a_idx_refused: assert property (hostWrEn && hostWrIdx > 4'hc |=> wrRejected_ff)
      else $error("bad index taken");
   a_trq_range: assert property (s_wr(IDX_TRQ_MAX) ##0 hostWrData > TRQ_MAX_HI
      |=> wrRejected_ff)
      else $error("torque ceiling over range taken");
   a_ofs_range: assert property (s_wr(IDX_SPD_OFS) ##0 ($signed(hostWrData) < $signed(SPD_OFS_LO)
      || $signed(hostWrData) > $signed(SPD_OFS_HI)) |=> wrRejected_ff)
      else $error("speed offset out of range taken");
   a_imm_apply: assert property (s_wr(IDX_SPD_GAIN) ##1 wrAccepted_ff
      |=> spdGain_ff == $past(hostWrData, 2))
      else $error("class A value not applied");
   a_cfg_apply: assert property (cfgCmd && pending_ff[11] && !hostWrEn && !$past(hostWrEn)
      |-> ##2 !pending_ff[11])
      else $error("configure did not apply class C");
   a_stop_only: assert property ($changed(classB_ff) |-> $past(motorStopped, 2) || $past(powerUp, 2))
      else $error("class B moved while running");
   a_power_only: assert property ($changed(classD_ff) |-> $past(powerUp, 2))
      else $error("class D moved without power-up");
   a_pend_set: assert property (s_wr(IDX_CLASSD) ##1 !powerUp |=> pending_ff[12])
      else $error("pending flag not set");
   a_reset_def: assert property ($fell(reset) |=> trqMax_ff == TRQ_MAX_DEF && threeWire_ff
      && startInhibit_ff)
      else $error("defaults wrong after reset");
endmodule : pcc_commit_sva
bind pcc_commit_ctrl pcc_commit_sva chk_u (.sys_clk(sys_clk), .reset(reset), .hostWrEn(hostWrEn),
   .hostWrIdx(hostWrIdx), .hostWrData(hostWrData), .motorStopped(motorStopped), .cfgCmd(cfgCmd),
   .powerUp(powerUp), .wrAccepted_ff(wrAccepted_ff), .wrRejected_ff(wrRejected_ff),
   .pending_ff(pending_ff), .trqMax_ff(trqMax_ff), .spdGain_ff(spdGain_ff),
   .threeWire_ff(threeWire_ff), .startInhibit_ff(startInhibit_ff), .classB_ff(classB_ff),
   .classD_ff(classD_ff));
`default_nettype wire

//--- bench/pcc_host_model.sv
// Purpose: Setup host that writes parameters and issues configure
// Assumes: Signals change at the falling edge
// Notes: Out of range values are sent only when a test asks for refusal
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
   // Clock
   input wire logic sys_clk,
   // Write port and command
   output logic hostWrEn,
   output logic [3:0] hostWrIdx,
   output logic [31:0] hostWrData,
   output logic cfgCmd,
   // Answer
   input wire logic wrAccepted_ff
);
   initial begin
      hostWrEn = 1'b0;
      hostWrIdx = 4'h0;
      hostWrData = 32'h0;
      cfgCmd = 1'b0;
   end
   // One write strobe; ranges kept by the caller's table
   task automatic write(input logic [3:0] idx, input logic [31:0] val, output logic ok);
      @(negedge sys_clk);
      hostWrEn = 1'b1;
      hostWrIdx = idx;
      hostWrData = val;
      @(negedge sys_clk);
      hostWrEn = 1'b0;
      hostWrData = ~val; // Released bus must not keep the old word
      ok = wrAccepted_ff;
   endtask : write
   // One configure pulse
   task automatic cfg();
      @(negedge sys_clk);
      cfgCmd = 1'b1;
      @(negedge sys_clk);
      cfgCmd = 1'b0;
   endtask : cfg
endmodule : pcc_host_model
`default_nettype wire

//--- bench/tb_parameter_commit_control.sv
// Purpose: Self-checking bench for the commit control block
// Assumes: Inputs change at the falling edge
// Notes: Row table for range checks, hand tests for commit timing
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_parameter_commit_control;
   import pcc_pkg::*;
   typedef struct {logic [3:0] idx; logic [31:0] d; logic ok;} pcc_row_s;
   logic sys_clk, reset, hostWrEn, cfgCmd, motorStopped, powerUp, wrAcc, wrRej, ok;
   logic threeWire, startInh, onEn, pwrEn;
   logic [3:0] hostWrIdx;
   logic [31:0] hostWrData, trqMax, spdGain, spdOfs, trqGain, trqOfs, ovlDelay, onTh, pwrTh;
   logic [31:0] clsB, clsC, clsD;
   logic [12:0] pend;
   int errors = 0;
   int checks_done = 0;
   // Boundary writes: values just inside or just outside their range, last row an unused index 4'hd
   pcc_row_s rows [17] = '{'{IDX_TRQ_MAX, 32'hc8, 1'b1}, '{IDX_TRQ_MAX, 32'hc9, 1'b0},
      '{IDX_SPD_GAIN, 32'hc4e, 1'b1}, '{IDX_SPD_GAIN, 32'hc4f, 1'b0},
      '{IDX_SPD_OFS, 32'h5dd, 1'b0}, '{IDX_SPD_OFS, 32'hfffffa23, 1'b0},
      '{IDX_SPD_OFS, 32'hfffffa24, 1'b1}, '{IDX_TRQ_GAIN, 32'hc8, 1'b1},
      '{IDX_TRQ_GAIN, 32'hc9, 1'b0}, '{IDX_TRQ_OFS, 32'h65, 1'b0},
      '{IDX_TRQ_OFS, 32'hffffff9c, 1'b1}, '{IDX_OVL_DELAY, 32'h0, 1'b0},
      '{IDX_OVL_DELAY, 32'h1, 1'b1}, '{IDX_ONTIME_TH, 32'h1, 1'b1},
      '{IDX_ONTIME_TH, 32'h3b9aca00, 1'b0}, '{IDX_PWRCNT_TH, 32'h3b9ac9ff, 1'b1},
      '{4'hd, 32'h0, 1'b0}};
   pcc_commit_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .hostWrEn(hostWrEn),
      .hostWrIdx(hostWrIdx), .hostWrData(hostWrData), .motorStopped(motorStopped),
      .cfgCmd(cfgCmd), .powerUp(powerUp), .wrAccepted_ff(wrAcc), .wrRejected_ff(wrRej),
      .pending_ff(pend), .trqMax_ff(trqMax), .spdGain_ff(spdGain), .spdOfs_ff(spdOfs),
      .trqGain_ff(trqGain), .trqOfs_ff(trqOfs), .threeWire_ff(threeWire),
      .ovlDelay_ff(ovlDelay), .startInhibit_ff(startInh), .onTimeTh_ff(onTh),
      .onTimeThEn_ff(onEn), .pwrCntTh_ff(pwrTh), .pwrCntThEn_ff(pwrEn), .classB_ff(clsB),
      .classC_ff(clsC), .classD_ff(clsD));
   pcc_host_model host_u (.sys_clk(sys_clk), .hostWrEn(hostWrEn), .hostWrIdx(hostWrIdx),
      .hostWrData(hostWrData), .cfgCmd(cfgCmd), .wrAccepted_ff(wrAcc));
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // Waits whole cycles on the driving edge
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle
   // Watchdog far beyond the roughly 90 cycles the tests need
   initial begin
      #20000;
      errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      motorStopped = 1'b0;
      powerUp = 1'b0;
      idle(20);
      reset = 1'b0;
      `CHK({trqMax, spdGain, trqGain, ovlDelay}, {32'hc8, 32'h280, 32'h2b, 32'h64})
      `CHK({threeWire, startInh, onEn, pwrEn, pend}, {4'b1100, 13'h0})
      idle(2);
      `CHK({trqMax, spdGain, ovlDelay, threeWire, startInh}, {32'hc8, 32'h280, 32'h64, 2'b11})
      $display("test defaults done");
      foreach (rows[i]) begin
         host_u.write(rows[i].idx, rows[i].d, ok);
         `CHK({ok, wrRej}, {rows[i].ok, !rows[i].ok})
      end
      idle(1);
      `CHK({trqMax, spdGain, spdOfs, ovlDelay}, {32'hc8, 32'hc4e, 32'hfffffa24, 32'h1})
      `CHK({trqOfs, pwrTh, pwrEn, onEn}, {32'hffffff9c, 32'h3b9ac9ff, 2'b11})
      `CHK({trqGain, onTh}, {32'hc8, 32'h1})
      $display("test ranges done");
      host_u.write(IDX_RUN_SCHEME, RUN_2WIRE, ok);
      host_u.write(IDX_CLASSB, 32'h5, ok);
      idle(2);
      `CHK({threeWire, pend[10], clsB}, {2'b01, 32'h0})
      motorStopped = 1'b1;
      idle(3);
      `CHK({pend[10], clsB}, {1'b0, 32'h5})
      $display("test stop apply done");
      host_u.write(IDX_CLASSC, 32'h7, ok);
      host_u.write(IDX_START_INH, START_INH_DIS, ok);
      host_u.write(IDX_CLASSD, 32'h9, ok);
      idle(2);
      `CHK({startInh, pend[12:11]}, 3'b111)
      host_u.cfg();
      idle(2);
      `CHK({clsC, startInh, clsD, pend[12]}, {32'h7, 1'b0, 32'h0, 1'b1})
      host_u.write(IDX_CLASSC, 32'h8, ok);
      powerUp = 1'b1;
      idle(1);
      powerUp = 1'b0;
      idle(3);
      `CHK({clsD, clsC, pend[12]}, {32'h9, 32'h8, 1'b0})
      `CHK({ovlDelay, clsB, trqMax}, {32'h1, 32'h5, 32'hc8})
      $display("test configure and power-up done");
      reset = 1'b1;
      idle(2);
      reset = 1'b0;
      `CHK({clsC, clsD, threeWire, startInh}, {64'h0, 2'b11})
      idle(2);
      `CHK({trqMax, ovlDelay, clsB, clsC, pend}, {32'hc8, 32'h64, 64'h0, 13'h0})
      `CHK({threeWire, startInh, onEn, pwrEn}, 4'b1100)
      $display("test second reset done");
      report_and_stop();
   end
endmodule : tb_parameter_commit_control
`default_nettype wire

//--- rtl/pcc_commit_ctrl.sv
// Purpose: Holds user parameters and decides when writes take effect
// Assumes: Host writes arrive as a one-cycle strobe with index and data
// Notes: powerUp models a supply cycle; reset clears the storage model
// What this block does
// [R1] Every accepted write kept in retained storage
// [R2] Class A applies right after write
// [R3] Class B applies once motor stops
// [R4] Class C applies on configure or power-up
// [R5] Class D applies only on power-up
// [R6] Torque ceiling 0 to 200, default 200
// [R7] Speed gain 0 to 3150, default 640
// [R8] Speed offset -1500 to +1500, default 0
// [R9] Torque gain 0 to 200, default 43
// [R10] Torque offset -100 to +100, default 0
// [R11] Run scheme two or three wire, default three
// [R12] Overload delay 0.1-10.0 s, immediate, default 10
// [R13] Start inhibit default enable, class C
// [R14] On-time threshold, zero disables, default zero
// [R15] Power-up count threshold, zero disables, default zero
// [R16] Pending flag set on class B, C or D write, cleared on apply
`timescale 1ns/1ps
`default_nettype none
module pcc_commit_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Host write port
   input wire logic hostWrEn,
   input wire logic [3:0] hostWrIdx,
   input wire logic [pcc_pkg::DATA_W-1:0] hostWrData,
   // Commit events
   input wire logic motorStopped,
   input wire logic cfgCmd,
   input wire logic powerUp,
   // Write status
   output logic wrAccepted_ff,
   output logic wrRejected_ff,
   output logic [pcc_pkg::NUM_PARAMS-1:0] pending_ff,
   // Active settings
   output logic [pcc_pkg::DATA_W-1:0] trqMax_ff,
   output logic [pcc_pkg::DATA_W-1:0] spdGain_ff,
   output logic [pcc_pkg::DATA_W-1:0] spdOfs_ff,
   output logic [pcc_pkg::DATA_W-1:0] trqGain_ff,
   output logic [pcc_pkg::DATA_W-1:0] trqOfs_ff,
   output logic threeWire_ff,
   output logic [pcc_pkg::DATA_W-1:0] ovlDelay_ff,
   output logic startInhibit_ff,
   output logic [pcc_pkg::DATA_W-1:0] onTimeTh_ff,
   output logic onTimeThEn_ff,
   output logic [pcc_pkg::DATA_W-1:0] pwrCntTh_ff,
   output logic pwrCntThEn_ff,
   output logic [pcc_pkg::DATA_W-1:0] classB_ff,
   output logic [pcc_pkg::DATA_W-1:0] classC_ff,
   output logic [pcc_pkg::DATA_W-1:0] classD_ff
);
   import pcc_pkg::*;

   // Class of each parameter index
   function automatic pcc_class_e classOf(input logic [3:0] idx);
      pcc_class_e c;
      c = CLS_A;
      if (idx == IDX_START_INH || idx == IDX_CLASSC) begin
         c = CLS_C; // [R13]
      end else if (idx == IDX_CLASSB) begin
         c = CLS_B;
      end else if (idx == IDX_CLASSD) begin
         c = CLS_D;
      end else begin
         c = CLS_A; // [R12]
      end
      return c;
   endfunction : classOf

   // Factory default of each parameter index
   function automatic logic [DATA_W-1:0] defaultOf(input logic [3:0] idx);
      logic [DATA_W-1:0] d;
      d = GENERIC_DEF;
      if (idx == IDX_TRQ_MAX) begin
         d = TRQ_MAX_DEF; // [R6]
      end else if (idx == IDX_SPD_GAIN) begin
         d = SPD_GAIN_DEF; // [R7]
      end else if (idx == IDX_SPD_OFS || idx == IDX_TRQ_OFS) begin
         d = ZERO_DEF; // [R8] [R10]
      end else if (idx == IDX_TRQ_GAIN) begin
         d = TRQ_GAIN_DEF; // [R9]
      end else if (idx == IDX_RUN_SCHEME) begin
         d = RUN_3WIRE; // [R11]
      end else if (idx == IDX_OVL_DELAY) begin
         d = OVL_DELAY_HI; // [R12]
      end else if (idx == IDX_START_INH) begin
         d = START_INH_EN; // [R13]
      end else if (idx == IDX_ONTIME_TH || idx == IDX_PWRCNT_TH) begin
         d = ZERO_DEF; // [R14] [R15]
      end else begin
         d = GENERIC_DEF;
      end
      return d;
   endfunction : defaultOf

   // Range check; out-of-range writes are refused, never stored
   function automatic logic inRange(input logic [3:0] idx, input logic [DATA_W-1:0] v);
      logic ok;
      ok = 1'b0;
      if (idx == IDX_TRQ_MAX || idx == IDX_TRQ_GAIN) begin
         ok = (v <= TRQ_MAX_HI); // [R6] [R9]
      end else if (idx == IDX_SPD_GAIN) begin
         ok = (v <= SPD_GAIN_HI); // [R7]
      end else if (idx == IDX_SPD_OFS) begin
         ok = ($signed(v) >= $signed(SPD_OFS_LO)) && ($signed(v) <= $signed(SPD_OFS_HI)); // [R8]
      end else if (idx == IDX_TRQ_OFS) begin
         ok = ($signed(v) >= $signed(TRQ_OFS_LO)) && ($signed(v) <= $signed(TRQ_OFS_HI)); // [R10]
      end else if (idx == IDX_RUN_SCHEME) begin
         ok = (v == RUN_2WIRE) || (v == RUN_3WIRE); // [R11]
      end else if (idx == IDX_OVL_DELAY) begin
         ok = (v >= OVL_DELAY_LO) && (v <= OVL_DELAY_HI); // [R12]
      end else if (idx == IDX_START_INH) begin
         ok = (v == START_INH_DIS) || (v == START_INH_EN); // [R13]
      end else if (idx == IDX_ONTIME_TH || idx == IDX_PWRCNT_TH) begin
         ok = (v <= THRESH_HI); // [R14] [R15]
      end else if (idx == IDX_CLASSB || idx == IDX_CLASSC || idx == IDX_CLASSD) begin
         ok = 1'b1;
      end else begin
         ok = 1'b0;
      end
      return ok;
   endfunction : inRange

   logic wrOk;
   logic [NUM_PARAMS-1:0] slotPending;
   logic [DATA_W-1:0] activeVal [NUM_PARAMS];

   assign wrOk = hostWrEn && inRange(hostWrIdx, hostWrData);

   // One slot per parameter; slot index equals the parameter index
   for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_slot
      localparam logic [3:0] IDX = 4'(i);
      pcc_param_slot u_slot (
         .sys_clk(sys_clk),
         .reset(reset),
         .cls(classOf(IDX)),
         .defVal(defaultOf(IDX)),
         .wrEn(wrOk && hostWrIdx == IDX), // [R1]
         .wrData(hostWrData),
         .motorStopped(motorStopped),
         .cfgCmd(cfgCmd),
         .powerUp(powerUp || reset),
         .storedVal(),
         .activeVal(activeVal[i]),
         .pending(slotPending[i])
      );
   end

   // Write answer, one cycle after the strobe
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrAccepted_ff <= 1'b0;
         wrRejected_ff <= 1'b0;
      end else begin
         wrAccepted_ff <= wrOk;
         wrRejected_ff <= hostWrEn && !wrOk; // [R6]
      end
   end

   // Pending flags registered out
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pending_ff <= '0;
      end else begin
         pending_ff <= slotPending; // [R16]
      end
   end

   // Active settings registered out; adds one cycle after the slot update
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trqMax_ff <= TRQ_MAX_DEF;
         spdGain_ff <= SPD_GAIN_DEF;
         spdOfs_ff <= ZERO_DEF;
         trqGain_ff <= TRQ_GAIN_DEF;
         trqOfs_ff <= ZERO_DEF;
         threeWire_ff <= 1'b1;
         ovlDelay_ff <= OVL_DELAY_HI;
         startInhibit_ff <= 1'b1;
         onTimeTh_ff <= ZERO_DEF;
         onTimeThEn_ff <= 1'b0;
         pwrCntTh_ff <= ZERO_DEF;
         pwrCntThEn_ff <= 1'b0;
         classB_ff <= GENERIC_DEF;
         classC_ff <= GENERIC_DEF;
         classD_ff <= GENERIC_DEF;
      end else begin
         trqMax_ff <= activeVal[IDX_TRQ_MAX];
         spdGain_ff <= activeVal[IDX_SPD_GAIN];
         spdOfs_ff <= activeVal[IDX_SPD_OFS];
         trqGain_ff <= activeVal[IDX_TRQ_GAIN];
         trqOfs_ff <= activeVal[IDX_TRQ_OFS];
         threeWire_ff <= activeVal[IDX_RUN_SCHEME] == RUN_3WIRE; // [R11]
         ovlDelay_ff <= activeVal[IDX_OVL_DELAY];
         startInhibit_ff <= activeVal[IDX_START_INH] == START_INH_EN; // [R13]
         onTimeTh_ff <= activeVal[IDX_ONTIME_TH];
         onTimeThEn_ff <= activeVal[IDX_ONTIME_TH] != ZERO_DEF; // [R14]
         pwrCntTh_ff <= activeVal[IDX_PWRCNT_TH];
         pwrCntThEn_ff <= activeVal[IDX_PWRCNT_TH] != ZERO_DEF; // [R15]
         classB_ff <= activeVal[IDX_CLASSB];
         classC_ff <= activeVal[IDX_CLASSC];
         classD_ff <= activeVal[IDX_CLASSD];
      end
   end
endmodule : pcc_commit_ctrl
`default_nettype wire

//--- rtl/pcc_param_slot.sv
// Purpose: One parameter: stored copy, pending flag and active copy
// Assumes: Stored copy stands in for the nonvolatile cell
// Notes: Class decides when the stored value is copied to the active one
`timescale 1ns/1ps
`default_nettype none
module pcc_param_slot (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Static setup
   input wire pcc_pkg::pcc_class_e cls,
   input wire logic [pcc_pkg::DATA_W-1:0] defVal,
   // Commit events
   input wire logic wrEn,
   input wire logic [pcc_pkg::DATA_W-1:0] wrData,
   input wire logic motorStopped,
   input wire logic cfgCmd,
   input wire logic powerUp,
   // State out
   output logic [pcc_pkg::DATA_W-1:0] storedVal,
   output logic [pcc_pkg::DATA_W-1:0] activeVal,
   output logic pending
);
   import pcc_pkg::*;

   logic storedValid_ff;
   logic [DATA_W-1:0] stored_ff;
   logic [DATA_W-1:0] active_ff;
   logic activeValid_ff;
   logic pending_ff;
   logic commit;
   logic [DATA_W-1:0] srcVal;

   // Stored copy keeps its value across power-up; only reset loads default
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         storedValid_ff <= 1'b0;
         stored_ff <= '0;
      end else if (wrEn) begin
         storedValid_ff <= 1'b1; // [R1]
         stored_ff <= wrData; // [R1]
      end
   end

   assign srcVal = storedValid_ff ? stored_ff : defVal;

   // When the stored copy may move into the active copy
   always_comb begin
      commit = 1'b0;
      case (cls)
         CLS_A: commit = wrEn | powerUp; // [R2]
         CLS_B: commit = (pending_ff & motorStopped) | powerUp; // [R3]
         CLS_C: commit = (pending_ff & cfgCmd) | powerUp; // [R4]
         CLS_D: commit = powerUp; // [R5]
         default: commit = 1'b0;
      endcase
   end

   // Class A takes the fresh write directly so it applies in the same step
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         active_ff <= '0;
      end else if (cls == CLS_A && wrEn) begin
         active_ff <= wrData; // [R2]
      end else if (commit) begin
         active_ff <= srcVal;
      end
   end

   // Until the first apply the active copy shows the factory default;
   // this keeps the reset branch constant and avoids a zero glitch after reset
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         activeValid_ff <= 1'b0;
      end else if ((cls == CLS_A && wrEn) || commit) begin
         activeValid_ff <= 1'b1;
      end
   end

   // A new write wins over a commit in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pending_ff <= 1'b0;
      end else if (wrEn && cls != CLS_A) begin
         pending_ff <= 1'b1; // [R16]
      end else if (commit) begin
         pending_ff <= 1'b0; // [R16]
      end
   end

   assign storedVal = srcVal;
   assign activeVal = activeValid_ff ? active_ff : defVal;
   assign pending = pending_ff;
endmodule : pcc_param_slot
`default_nettype wire

//--- rtl/pcc_pkg.sv
// Purpose: Shared constants for the parameter commit control block
// Assumes: One 200 MHz clock, parameters addressed by a small index
// Notes: Values are in the units the host tool uses
package pcc_pkg;
   // Parameter indices
   localparam logic [3:0] IDX_TRQ_MAX = 4'h0;
   localparam logic [3:0] IDX_SPD_GAIN = 4'h1;
   localparam logic [3:0] IDX_SPD_OFS = 4'h2;
   localparam logic [3:0] IDX_TRQ_GAIN = 4'h3;
   localparam logic [3:0] IDX_TRQ_OFS = 4'h4;
   localparam logic [3:0] IDX_RUN_SCHEME = 4'h5;
   localparam logic [3:0] IDX_OVL_DELAY = 4'h6;
   localparam logic [3:0] IDX_START_INH = 4'h7;
   localparam logic [3:0] IDX_ONTIME_TH = 4'h8;
   localparam logic [3:0] IDX_PWRCNT_TH = 4'h9;
   localparam logic [3:0] IDX_CLASSB = 4'ha;
   localparam logic [3:0] IDX_CLASSC = 4'hb;
   localparam logic [3:0] IDX_CLASSD = 4'hc;
   localparam int NUM_PARAMS = 13;
   localparam int DATA_W = 32;

   // Update classes
   typedef enum logic [1:0] {
      CLS_A = 2'b00,
      CLS_B = 2'b01,
      CLS_C = 2'b10,
      CLS_D = 2'b11
   } pcc_class_e;

   // Ranges and factory defaults
   localparam logic [31:0] TRQ_MAX_HI = 32'h0000_00c8;     // 200 %
   localparam logic [31:0] TRQ_MAX_DEF = 32'h0000_00c8;
   localparam logic [31:0] SPD_GAIN_HI = 32'h0000_0c4e;    // 3150 r/min/V
   localparam logic [31:0] SPD_GAIN_DEF = 32'h0000_0280;   // 640
   localparam logic [31:0] SPD_OFS_LO = 32'hffff_fa24;     // -1500
   localparam logic [31:0] SPD_OFS_HI = 32'h0000_05dc;     // +1500
   localparam logic [31:0] TRQ_GAIN_HI = 32'h0000_00c8;    // 200 %/V
   localparam logic [31:0] TRQ_GAIN_DEF = 32'h0000_002b;   // 43
   localparam logic [31:0] TRQ_OFS_LO = 32'hffff_ff9c;     // -100
   localparam logic [31:0] TRQ_OFS_HI = 32'h0000_0064;     // +100
   localparam logic [31:0] RUN_2WIRE = 32'h0000_0000;
   localparam logic [31:0] RUN_3WIRE = 32'h0000_0001;
   localparam logic [31:0] OVL_DELAY_LO = 32'h0000_0001;   // 0.1 s, tenths
   localparam logic [31:0] OVL_DELAY_HI = 32'h0000_0064;   // 10.0 s
   localparam logic [31:0] START_INH_DIS = 32'h0000_0000;
   localparam logic [31:0] START_INH_EN = 32'h0000_0001;
   localparam logic [31:0] THRESH_HI = 32'h3b9a_c9ff;      // 999,999,999
   localparam logic [31:0] ZERO_DEF = 32'h0000_0000;
   localparam logic [31:0] GENERIC_DEF = 32'h0000_0000;
endpackage : pcc_pkg
